/* logic/gpb_defines.vh */
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH
// ==================================================================
// Register indexes; the byte address is four times the index.
`define GPB_IDX_PORT 10'h005
`define GPB_IDX_OPTION 10'h081
`define GPB_IDX_DIR 10'h085
`define GPB_IDX_ANALOG 10'h091
`define GPB_IDX_PULLUP 10'h095
`define GPB_IDX_CHANGE_EN 10'h096
`define GPB_IDX_CONFIG 10'h0a0
`define GPB_IDX_CHANGE_FLAG 10'h0a1
// ==================================================================
// Reset values.
`define GPB_RST_DIR 6'h3f
`define GPB_RST_OPTION 8'hff
`define GPB_RST_ANALOG 8'hff
`define GPB_RST_PULLUP 6'h3f
`define GPB_RST_CHANGE_EN 6'h00
`define GPB_RST_CONFIG 3'h0
`define GPB_RST_LATCH 6'h00
// ==================================================================
// Field positions.
`define GPB_OPT_PU_OFF_BIT 7
`define GPB_CFG_MASTER_CLEAR_ENABLE_FUSE_BIT 0
`define GPB_CFG_XTAL_BIT 1
`define GPB_CFG_VREF_BIT 2
`define GPB_INPUT_ONLY_PIN 3
`define GPB_VREF_PIN 1
`define GPB_OSC_PIN_LO 4
// ==================================================================
// Bus responses.
`define GPB_RESP_OKAY 2'b00
`define GPB_RESP_SLVERR 2'b10
`endif

/* logic/gpb_port.v */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "gpb_defines.vh"
// Contract
// - Six pin bits; bits 7:6 read zero.
// - Direction 1 tristates pin, 0 drives latch.
// - Pin 3 input only; direction reads 1.
// - Port read gives pins; write loads latch.
// - Port write is read-modify-write of pins.
// - Master-clear enabled makes pin 3 read zero.
// - Analog-selected pin reads zero.
// - Direction still governs analog-selected pins.
// - Reference output disables pin 1 driver only.
// - Directions reset to inputs; latch undefined, but reset loads it with zero here.
// - Crystal modes force direction 5:4 reads 1.
// - Every pin has own pull-up enable bit.
// - Output pins have pull-up switched off.
// - Global pull-up control resets to disabled.
// - Master-clear pin 3 pull-up forced on.
// - Every pin has change-detect and pull-up options.
// - Pin pull-up needs global pull-up permission.
module gpb_port #(
	parameter NPINS = 6,
	parameter AW = 12
) (
	input wire ref_clk,
	input wire rst_b,
	input wire [AW-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [NPINS-1:0] pin_in,
	output reg [NPINS-1:0] pin_out,
	output reg [NPINS-1:0] pin_oe,
	output reg [NPINS-1:0] pin_pullup_on
);

	// ==================================================================
	// Pin input synchroniser.
	reg [NPINS-1:0] pin_meta;
	reg [NPINS-1:0] pin_sync;

	// Pins are asynchronous to ref_clk, so two stages come first.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= {NPINS{1'b0}};
			pin_sync <= {NPINS{1'b0}};
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// ==================================================================
	// Register state.
	reg [NPINS-1:0] port_latch;
	reg [NPINS-1:0] dir_store;
	reg [7:0] option_reg;
	reg [7:0] analog_sel;
	reg [NPINS-1:0] pin_pullup_enable;
	reg [NPINS-1:0] change_en;
	reg [NPINS-1:0] last_read;
	reg change_flag;
	reg [2:0] config_reg;

	wire master_clear_enable_fuse = config_reg[`GPB_CFG_MASTER_CLEAR_ENABLE_FUSE_BIT];
	wire xtal_mode = config_reg[`GPB_CFG_XTAL_BIT];
	wire vref_out = config_reg[`GPB_CFG_VREF_BIT];
	wire pu_global_off = option_reg[`GPB_OPT_PU_OFF_BIT];

	// ==================================================================
	// Effective direction and the value seen by a port read.
	reg [NPINS-1:0] dir_eff;
	reg [NPINS-1:0] port_read;

	always @* begin
		dir_eff = dir_store;
		dir_eff[`GPB_INPUT_ONLY_PIN] = 1'b1;
		if (xtal_mode) begin
			dir_eff[`GPB_OSC_PIN_LO+1:`GPB_OSC_PIN_LO] = 2'b11;
		end
		// Analog pins read zero whatever the pad level.
		port_read = pin_sync & ~analog_sel[NPINS-1:0];
		if (master_clear_enable_fuse) begin
			port_read[`GPB_INPUT_ONLY_PIN] = 1'b0;
		end
	end

	// ==================================================================
	// Pin drivers and pull-ups, one slice per pin.
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
			// Analog select is not looked at here: direction rules.
			always @* begin
				pin_out[gi] = port_latch[gi];
				pin_oe[gi] = ~dir_eff[gi];
				if (gi == `GPB_VREF_PIN && vref_out) begin
					pin_oe[gi] = 1'b0;
				end
				// Pull-up needs its own bit, global leave, input mode.
				pin_pullup_on[gi] = pin_pullup_enable[gi] &
					~pu_global_off & dir_eff[gi];
				if (gi == `GPB_INPUT_ONLY_PIN && master_clear_enable_fuse) begin
					pin_pullup_on[gi] = 1'b1;
				end
			end
		end
	endgenerate

	// ==================================================================
	// Write channel: address and data are held until both are in.
	reg aw_held;
	reg w_held;
	reg [AW-1:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_hit;

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;

	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_held & w_held & ~s_axi_bvalid;
	wire [9:0] w_idx = aw_addr[11:2];
	wire b_lane = w_strb[0];

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {AW{1'b0}};
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GPB_RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_hit ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==================================================================
	// Address decode for writes.
	always @* begin
		case (w_idx)
			`GPB_IDX_PORT, `GPB_IDX_OPTION, `GPB_IDX_DIR,
			`GPB_IDX_ANALOG, `GPB_IDX_PULLUP, `GPB_IDX_CHANGE_EN,
			`GPB_IDX_CONFIG, `GPB_IDX_CHANGE_FLAG: w_hit = 1'b1;
			default: w_hit = 1'b0;
		endcase
	end

	// ==================================================================
	// Read channel: one read at a time, data registered.
	assign s_axi_arready = ~s_axi_rvalid;

	wire ar_fire = s_axi_arvalid & s_axi_arready;
	wire [9:0] r_idx = s_axi_araddr[11:2];
	wire port_read_fire = ar_fire && r_idx == `GPB_IDX_PORT;
	reg [31:0] r_word;
	reg r_hit;

	// Unused upper lanes read zero, so pin bits 7:6 read zero too.
	always @* begin
		r_word = 32'h00000000;
		r_hit = 1'b1;
		case (r_idx)
			`GPB_IDX_PORT: r_word[NPINS-1:0] = port_read;
			`GPB_IDX_DIR: r_word[NPINS-1:0] = dir_eff;
			`GPB_IDX_OPTION: r_word[7:0] = option_reg;
			`GPB_IDX_ANALOG: r_word[7:0] = analog_sel;
			`GPB_IDX_PULLUP: r_word[NPINS-1:0] = pin_pullup_enable;
			`GPB_IDX_CHANGE_EN: r_word[NPINS-1:0] = change_en;
			`GPB_IDX_CONFIG: r_word[2:0] = config_reg;
			`GPB_IDX_CHANGE_FLAG: r_word[0] = change_flag;
			default: r_hit = 1'b0;
		endcase
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `GPB_RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= r_word;
			s_axi_rresp <= r_hit ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==================================================================
	// Register updates from writes.
	wire wr_lane = do_write & b_lane;

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_latch <= `GPB_RST_LATCH;
			dir_store <= `GPB_RST_DIR;
			option_reg <= `GPB_RST_OPTION;
			analog_sel <= `GPB_RST_ANALOG;
			pin_pullup_enable <= `GPB_RST_PULLUP;
			change_en <= `GPB_RST_CHANGE_EN;
			config_reg <= `GPB_RST_CONFIG;
		end else if (do_write) begin
			case (w_idx)
				// Pins are sampled first, lane 0 then overlays them.
				`GPB_IDX_PORT: port_latch <= b_lane ?
					w_data[NPINS-1:0] : port_read;
				`GPB_IDX_DIR: if (wr_lane) begin
					dir_store <= w_data[NPINS-1:0];
				end
				`GPB_IDX_OPTION: if (wr_lane) begin
					option_reg <= w_data[7:0];
				end
				`GPB_IDX_ANALOG: if (wr_lane) begin
					analog_sel <= w_data[7:0];
				end
				`GPB_IDX_PULLUP: if (wr_lane) begin
					pin_pullup_enable <= w_data[NPINS-1:0];
				end
				`GPB_IDX_CHANGE_EN: if (wr_lane) begin
					change_en <= w_data[NPINS-1:0];
				end
				`GPB_IDX_CONFIG: if (wr_lane) begin
					config_reg <= w_data[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ==================================================================
	// Change detection against the value of the last port access.
	wire port_wr = do_write && w_idx == `GPB_IDX_PORT;
	wire mismatch = |((pin_sync ^ last_read) & change_en);
	wire flag_clr = wr_lane && w_idx == `GPB_IDX_CHANGE_FLAG &&
		w_data[0];

	// A new mismatch beats a software clear in the same cycle.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			last_read <= {NPINS{1'b0}};
			change_flag <= 1'b0;
		end else begin
			if (port_read_fire || port_wr) begin
				last_read <= pin_sync;
			end
			if (mismatch) begin
				change_flag <= 1'b1;
			end else if (flag_clr) begin
				change_flag <= 1'b0;
			end
		end
	end

endmodule

/* testbench/gpb_port_monitor.sv */
`timescale 1ns/1ps
`include "gpb_defines.vh"
// ==================================================
// Pin and register checks seen only from the ports.
module gpb_port_monitor #(
	parameter NPINS = 6,
	parameter AW = 12
) (
	input wire ref_clk,
	input wire rst_b,
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire [NPINS-1:0] pin_out,
	input wire [NPINS-1:0] pin_oe,
	input wire [NPINS-1:0] pin_pullup_on
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Accepted requests; the index drops the byte lanes.
	wire [9:0] rd_idx = s_axi_araddr[11:2];
	wire [9:0] wr_idx = s_axi_awaddr[11:2];
	wire rd_go = s_axi_arvalid && s_axi_arready;
	wire wr_go = s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready;
	sequence dir_read;
		rd_go && rd_idx == `GPB_IDX_DIR;
	endsequence
	sequence master_clear_input_set;
		wr_go && wr_idx == `GPB_IDX_CONFIG &&
			s_axi_wstrb[0] && s_axi_wdata[0];
	endsequence
	a_pin3_never_driven: assert property (!pin_oe[3])
		else $error("input only pin driven");
	a_dir3_reads_one: assert property (dir_read |->
		##[1:3] (s_axi_rvalid && s_axi_rdata[3])) else $error("dir bit 3 low");
	a_upper_bits_zero: assert property ((rd_go &&
		(rd_idx == `GPB_IDX_PORT || rd_idx == `GPB_IDX_DIR)) |->
		##[1:3] (s_axi_rvalid && s_axi_rdata[31:6] == 26'h0))
		else $error("upper bits set");
	a_no_pullup_driven: assert property (
		(pin_pullup_on & pin_oe) == 6'h00)
		else $error("pull-up on driven pin");
	a_reset_all_inputs: assert property (
		$rose(rst_b) |-> pin_oe == 6'h00)
		else $error("pin driven after reset");
	a_reset_pullups_off: assert property (
		$rose(rst_b) |-> !pin_pullup_on)
		else $error("pull-up on after reset");
	a_oe_on_write: assert property (
		$changed(pin_oe) |-> $rose(s_axi_bvalid))
		else $error("driver enable moved without write");
	a_latch_on_write: assert property (
		$changed(pin_out) |-> $rose(s_axi_bvalid))
		else $error("latch moved without write");
	a_master_clear_input_pullup_on: assert property (
		master_clear_input_set |-> ##[1:3] pin_pullup_on[3])
		else $error("master clear pull-up off");
endmodule
bind gpb_port gpb_port_monitor #(.NPINS(NPINS), .AW(AW)) u_monitor (
	.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .pin_out, .pin_oe, .pin_pullup_on);

/* testbench/gpb_pad_model.sv */
`timescale 1ns/1ps
// ==================================================
// Board pads: device driver wins, then board, then pull-up.
module gpb_pad_model (
	input wire ref_clk,
	input wire [5:0] pin_out,
	input wire [5:0] pin_oe,
	input wire [5:0] pin_pullup_on,
	input wire [5:0] ext_en,
	input wire [5:0] ext_val,
	output wire [5:0] pin_in
);
	logic [5:0] last = 6'h00;
	// A floating pad flips every cycle so a missing drive never looks valid.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
		(~pin_oe & ~ext_en & (pin_pullup_on | ~last));
	// Remember the level for the floating case.
	always @(posedge ref_clk) begin
		last <= pin_in;
	end
endmodule

/* testbench/test_gpb_port.sv */
`timescale 1ns/1ps
`include "gpb_defines.vh"
// ==================================================
// Register tasks and port scenarios.
module test_gpb_port;
	logic ref_clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, got;
	logic [3:0] ws = 0;
	logic [1:0] resp;
	logic [5:0] ext_en = 0, ext_val = 0;
	wire awr, wrd, bv, arr, rv;
	wire [1:0] br, rr;
	wire [31:0] rdt;
	wire [5:0] po, poe, ppu, pin;
	wire [31:0] po32 = {26'h0, po}, oe32 = {26'h0, poe};
	wire [31:0] pu32 = {26'h0, ppu};
	int bad_count = 0, samples_checked = 0, cyc = 0;
	gpb_port uut (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.pin_in(pin), .pin_out(po), .pin_oe(poe), .pin_pullup_on(ppu));
	gpb_pad_model pads (.ref_clk(ref_clk), .pin_out(po), .pin_oe(poe),
		.pin_pullup_on(ppu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin));
	// Free-running system clock.
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard; the whole run needs under two hundred cycles.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			complete_run;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Ready is judged mid-cycle, so each item is dropped at the edge taking it.
	task wr(input logic [9:0] i, input logic [7:0] d, input logic s);
		logic a, w, b;
		@(posedge ref_clk);
		awa <= {i, 2'b00};
		wd <= {24'h0, d};
		ws <= {3'h0, s};
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(negedge ref_clk);
			a = awv && awr;
			w = wv && wrd;
			b = bv;
			resp = br;
			@(posedge ref_clk);
			if (a) awv <= 0;
			if (w) wv <= 0;
		end while (!b);
		bry <= 0;
	endtask
	task rd(input logic [9:0] i);
		logic a, r;
		@(posedge ref_clk);
		ara <= {i, 2'b00};
		arv <= 1;
		rry <= 1;
		do begin
			@(negedge ref_clk);
			a = arv && arr;
			r = rv;
			got = rdt;
			resp = rr;
			@(posedge ref_clk);
			if (a) arv <= 0;
		end while (!r);
		rry <= 0;
	endtask
	task rc(input logic [9:0] i, input logic [31:0] e);
		rd(i);
		chk(got, e);
	endtask
	// Main sequence.
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1;
		rc(`GPB_IDX_DIR, 32'h3f);
		rc(`GPB_IDX_OPTION, 32'hff);
		chk(pu32, 32'h0);
		ext_en <= 6'h3f;
		ext_val <= 6'h2a;
		rc(`GPB_IDX_PORT, 32'h0);
		wr(`GPB_IDX_ANALOG, 8'h00, 1);
		rc(`GPB_IDX_PORT, 32'h2a);
		ext_en <= 6'h08;
		wr(`GPB_IDX_DIR, 8'h00, 1);
		rc(`GPB_IDX_DIR, 32'h08);
		chk(oe32, 32'h37);
		wr(`GPB_IDX_PORT, 8'h15, 1);
		chk(po32, 32'h15);
		rc(`GPB_IDX_PORT, 32'h1d);
		wr(`GPB_IDX_DIR, 8'h3e, 1);
		ext_en <= 6'h3e;
		repeat (3) @(posedge ref_clk);
		wr(`GPB_IDX_PORT, 8'h00, 0);
		chk(po32, 32'h2b);
		wr(`GPB_IDX_CONFIG, 8'h01, 1);
		rc(`GPB_IDX_PORT, 32'h23);
		chk(pu32, 32'h08);
		wr(`GPB_IDX_DIR, 8'h00, 1);
		wr(`GPB_IDX_CONFIG, 8'h02, 1);
		rc(`GPB_IDX_DIR, 32'h38);
		wr(`GPB_IDX_CONFIG, 8'h04, 1);
		chk(oe32, 32'h35);
		rc(`GPB_IDX_DIR, 32'h08);
		wr(`GPB_IDX_DIR, 8'h01, 1);
		wr(`GPB_IDX_ANALOG, 8'h01, 1);
		chk(oe32, 32'h34);
		rc(`GPB_IDX_PORT, 32'h2a);
		wr(`GPB_IDX_CONFIG, 8'h00, 1);
		wr(`GPB_IDX_OPTION, 8'h7f, 1);
		wr(`GPB_IDX_PULLUP, 8'h05, 1);
		chk(pu32, 32'h01);
		wr(`GPB_IDX_DIR, 8'h3f, 1);
		chk(pu32, 32'h05);
		wr(`GPB_IDX_OPTION, 8'hff, 1);
		chk(pu32, 32'h0);
		wr(`GPB_IDX_CHANGE_EN, 8'h3f, 1);
		rc(`GPB_IDX_CHANGE_EN, 32'h3f);
		// Drive every pad so no floating pin keeps a mismatch alive.
		ext_en <= 6'h3f;
		repeat (3) @(posedge ref_clk);
		rd(`GPB_IDX_PORT);
		wr(`GPB_IDX_CHANGE_FLAG, 8'h01, 1);
		rc(`GPB_IDX_CHANGE_FLAG, 32'h0);
		ext_val <= 6'h15;
		repeat (3) @(posedge ref_clk);
		rc(`GPB_IDX_CHANGE_FLAG, 32'h1);
		// An unmapped place answers with a slave error both ways.
		rd(10'h003);
		chk({30'h0, resp}, 32'h2);
		wr(10'h003, 8'h00, 1);
		chk({30'h0, resp}, 32'h2);
		rst_b <= 0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1;
		rc(`GPB_IDX_DIR, 32'h3f);
		complete_run;
	end
endmodule
